// [hw/pll_ctrl.sv]
/*
  Digital control around the loop: post-scale dividers with duty,
  coarse and fine phase, and reference switchover, behind AXI4-Lite.
  Assumes reference clocks and VCO taps arrive as levels synchronous
  to clk and well below its rate.
*/
// Added by the designer: the AXI4-Lite register port and the register offsets.
// Function
// - chained counters divide by their product
// - chaining fixed by parameter, never by software
// - separate high and low counts shape duty
// - duty step is fifty percent over divide; code steps by one tick, a full period over divide
// - every counter picks one of eight taps; code feeds a chained counter from the previous counter instead
// - start held off initial count minus one
// - runtime phase change only by tap select
// - auto mode leaves a stopped active input
// - manual request edge, held three cycles, swaps
// - override mode request beats automatic switching
// - two loss flags and selected input out
// - state machine drives reference select
// - auto mode alternates without limit
// - no switch when both inputs are stopped
// - loss flag means input stopped toggling
// - loss flags valid within twenty percent
// - selected indicator always shows feeding input
// - after two edges flag loss and switch
// - divide equals high plus low, each 1..256
// - primary input selected after reset
// - gate on old fall, switch on new fall
// - wait for target input before completing switch
`timescale 1ns/1ps
module pll_ctrl #(
  parameter int NUM_OUT = pll_ctrl_pkg::NUM_OUT,
  parameter logic [NUM_OUT:0] CASCADE = '0,
  parameter logic [(NUM_OUT+1)*pll_ctrl_pkg::INIT_W-1:0] INIT_VALUES =
    {(NUM_OUT+1){pll_ctrl_pkg::INIT_DEFAULT}}
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [pll_ctrl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pll_ctrl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // references and switch request
  input wire logic refClockPrimary,
  input wire logic refClockBackup,
  input wire logic switchReq,
  // vco taps
  input wire logic [pll_ctrl_pkg::NUM_TAPS-1:0] vcoPhase,
  // outputs
  output logic refClockOut,
  output logic lossPrimary,
  output logic lossBackup,
  output logic activeSel,
  output logic [NUM_OUT-1:0] clkOut,
  output logic fbClkOut
);
  import pll_ctrl_pkg::*;

  localparam int NCNT = NUM_OUT + 1;

  function automatic logic [31:0] mergeWord(input logic [31:0] oldW,
                                            input logic [31:0] newW,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = oldW;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newW[8*b +: 8];
      end
    end
    return res;
  endfunction

  // software state
  logic [1:0] mode_reg;
  logic [CNT_W-1:0] hi_reg [NCNT];
  logic [CNT_W-1:0] lo_reg [NCNT];
  logic [TAP_W-1:0] tap_reg [NCNT];

  // bus capture
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic [31:0] phaseRd;
  logic [31:0] phaseNew;
  logic [31:0] rdWord;
  logic rdHit;
  logic wrHit;

  // switchover
  sw_state_t state_reg;
  logic pS_reg, pQ_reg, bS_reg, bQ_reg;
  logic pRise, pFall, bRise, bFall;
  logic reqMeta_reg, reqSync_reg, reqPrev_reg;
  logic reqHold_reg;
  logic [1:0] reqCnt_reg;
  logic reqFire;
  logic manualPend_reg;
  logic gated_reg;
  logic selRise, oldLvl, newFall;
  logic activeLost, otherLost;
  logic autoGo, manGo, accept, gateNow;

  // counters
  logic [NUM_TAPS-1:0] vcoPrev_reg;
  logic [NUM_TAPS-1:0] vcoRise;
  logic [NCNT-1:0] cntOut;
  logic [NCNT-1:0] cntRise;

  // write channel: address and data accepted in either order
  assign doWrite = ~awready & ~wready & ~bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_comb begin
    phaseRd = '0;
    for (int i = 0; i < NCNT; i++) begin
      phaseRd[i*TAP_W +: TAP_W] = tap_reg[i];
    end
  end

  assign phaseNew = mergeWord(phaseRd, wData_reg, wStrb_reg);

  always_comb begin
    wrHit = (awAddr_reg == CTRL_OFS) || (awAddr_reg == STATUS_OFS) ||
            (awAddr_reg == PHASE_OFS);
    for (int i = 0; i < NCNT; i++) begin
      if (awAddr_reg == 8'(CNT_BASE + 4*i)) begin
        wrHit = 1'b1;
      end
    end
  end

  // status is read-only; writes to it are accepted and dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= MODE_RESET;
      for (int i = 0; i < NCNT; i++) begin
        hi_reg[i] <= HI_RESET;
        lo_reg[i] <= LO_RESET;
        tap_reg[i] <= TAP_RESET;
      end
    end else if (doWrite) begin
      if (awAddr_reg == CTRL_OFS && wStrb_reg[0]) begin
        mode_reg <= wData_reg[1:0];
      end
      for (int i = 0; i < NCNT; i++) begin
        if (awAddr_reg == PHASE_OFS) begin
          tap_reg[i] <= phaseNew[i*TAP_W +: TAP_W];
        end
        if (awAddr_reg == 8'(CNT_BASE + 4*i)) begin
          if (wStrb_reg[0]) begin
            hi_reg[i] <= wData_reg[HI_LSB +: CNT_W];
          end
          if (wStrb_reg[1]) begin
            lo_reg[i] <= wData_reg[LO_LSB +: CNT_W];
          end
        end
      end
    end
  end

  // read channel
  always_comb begin
    rdWord = '0;
    rdHit = 1'b1;
    case (araddr)
      CTRL_OFS: rdWord[1:0] = mode_reg;
      STATUS_OFS: begin
        rdWord[ST_LOSS_P] = lossPrimary;
        rdWord[ST_LOSS_B] = lossBackup;
        rdWord[ST_ACTIVE] = activeSel;
        rdWord[ST_BUSY] = state_reg != SW_IDLE;
      end
      PHASE_OFS: rdWord = phaseRd;
      default: rdHit = 1'b0;
    endcase
    for (int i = 0; i < NCNT; i++) begin
      if (araddr == 8'(CNT_BASE + 4*i)) begin
        rdHit = 1'b1;
        rdWord[HI_LSB +: CNT_W] = hi_reg[i];
        rdWord[LO_LSB +: CNT_W] = lo_reg[i];
        rdWord[INIT_LSB +: INIT_W] = INIT_VALUES[i*INIT_W +: INIT_W];
        rdWord[CASC_BIT] = CASCADE[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdWord;
      rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // reference sampling and edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pS_reg <= 1'b0;
      pQ_reg <= 1'b0;
      bS_reg <= 1'b0;
      bQ_reg <= 1'b0;
    end else begin
      pS_reg <= refClockPrimary;
      pQ_reg <= pS_reg;
      bS_reg <= refClockBackup;
      bQ_reg <= bS_reg;
    end
  end

  assign pRise = pS_reg & ~pQ_reg;
  assign pFall = ~pS_reg & pQ_reg;
  assign bRise = bS_reg & ~bQ_reg;
  assign bFall = ~bS_reg & bQ_reg;

  // flags only meaningful with inputs close in rate
  ref_clock_sense u_sense_p (
    .clk(clk),
    .rstn(rstn),
    .ownRise(pRise),
    .otherRise(bRise),
    .lost(lossPrimary)
  );

  ref_clock_sense u_sense_b (
    .clk(clk),
    .rstn(rstn),
    .ownRise(bRise),
    .otherRise(pRise),
    .lost(lossBackup)
  );

  assign selRise = activeSel ? bRise : pRise;
  assign oldLvl = activeSel ? bS_reg : pS_reg;
  assign newFall = activeSel ? pFall : bFall;
  assign activeLost = activeSel ? lossBackup : lossPrimary;
  assign otherLost = activeSel ? lossPrimary : lossBackup;

  // switch request synchroniser and hold qualifier
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reqMeta_reg <= 1'b0;
      reqSync_reg <= 1'b0;
      reqPrev_reg <= 1'b0;
    end else begin
      reqMeta_reg <= switchReq;
      reqSync_reg <= reqMeta_reg;
      reqPrev_reg <= reqSync_reg;
    end
  end

  assign reqFire = reqHold_reg & reqSync_reg & selRise &
                   (reqCnt_reg == 2'(REQ_HOLD_EDGES - 1));

  // counted in edges of the feeding input, so slow inputs need longer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reqHold_reg <= 1'b0;
      reqCnt_reg <= '0;
    end else if (reqSync_reg && !reqPrev_reg) begin
      reqHold_reg <= 1'b1;
      reqCnt_reg <= '0;
    end else if (!reqSync_reg || reqFire) begin
      reqHold_reg <= 1'b0;
    end else if (reqHold_reg && selRise) begin
      reqCnt_reg <= reqCnt_reg + 1'b1;
    end
  end

  assign manGo = manualPend_reg & (mode_reg == MODE_MANUAL || mode_reg == MODE_OVERRIDE);
  assign autoGo = (mode_reg != MODE_MANUAL) & activeLost & ~otherLost;
  assign accept = (state_reg == SW_IDLE) & (manGo | autoGo);

  // a new qualified request wins over the clear on acceptance
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      manualPend_reg <= 1'b0;
    end else if (reqFire) begin
      manualPend_reg <= 1'b1;
    end else if (accept || mode_reg == MODE_AUTO) begin
      manualPend_reg <= 1'b0;
    end
  end

  // a lost input may be stuck high, so loss gates without a fall
  assign gateNow = (state_reg == SW_GATE_OLD) & (~oldLvl | activeLost);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SW_IDLE;
      activeSel <= 1'b0;
      gated_reg <= 1'b0;
    end else begin
      case (state_reg)
        SW_IDLE: begin
          if (accept) begin
            state_reg <= SW_GATE_OLD;
          end
        end
        SW_GATE_OLD: begin
          if (gateNow) begin
            gated_reg <= 1'b1;
            state_reg <= SW_WAIT_NEW;
          end
        end
        SW_WAIT_NEW: begin
          if (newFall) begin
            activeSel <= ~activeSel;
            gated_reg <= 1'b0;
            state_reg <= SW_IDLE;
          end
        end
        default: state_reg <= SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refClockOut <= 1'b0;
    end else if (gated_reg || gateNow) begin
      refClockOut <= 1'b0;
    end else begin
      refClockOut <= activeSel ? bS_reg : pS_reg;
    end
  end

  // vco tap edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vcoPrev_reg <= '0;
    end else begin
      vcoPrev_reg <= vcoPhase;
    end
  end

  assign vcoRise = vcoPhase & ~vcoPrev_reg;

  // last counter is the feedback multiplier, never chained
  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    logic tickSel;
    if (i > 0 && i < NUM_OUT && CASCADE[i]) begin : g_casc
      assign tickSel = cntRise[i-1];
    end else begin : g_tap
      assign tickSel = vcoRise[tap_reg[i]];
    end
    // duty resolution is one tick, a full period over the divide value
    post_scale_counter #(
      .CW(CNT_W),
      .IW(INIT_W)
    ) u_cnt (
      .clk(clk),
      .rstn(rstn),
      .tick(tickSel),
      .hiCount(hi_reg[i]),
      .loCount(lo_reg[i]),
      .initCount(INIT_VALUES[i*INIT_W +: INIT_W]),
      .outClk(cntOut[i]),
      .outRise(cntRise[i])
    );
  end

  assign clkOut = cntOut[NUM_OUT-1:0];
  assign fbClkOut = cntOut[NUM_OUT];
endmodule

// [hw/post_scale_counter.sv]
/*
  One post-scale divider: delayed start, then high and low phases.
  Assumes tick is a one-cycle pulse per counted clock edge.
*/
`timescale 1ns/1ps
module post_scale_counter #(
  parameter int CW = pll_ctrl_pkg::CNT_W,
  parameter int IW = pll_ctrl_pkg::INIT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // count input and settings
  input wire logic tick,
  input wire logic [CW-1:0] hiCount,
  input wire logic [CW-1:0] loCount,
  input wire logic [IW-1:0] initCount,
  // divided output
  output logic outClk,
  output logic outRise
);
  import pll_ctrl_pkg::*;

  logic [CW:0] hiEff;
  logic [CW:0] loEff;
  logic [CW:0] phaseCnt_reg;
  logic [IW-1:0] delay_reg;
  logic started_reg;
  logic startNow;

  // zero encodes the top count
  assign hiEff = {hiCount == '0, hiCount};
  assign loEff = {loCount == '0, loCount};
  assign startNow = tick & ~started_reg & (delay_reg >= initCount);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      started_reg <= 1'b0;
      delay_reg <= IW'(1);
    end else if (tick && !started_reg) begin
      if (startNow) begin
        started_reg <= 1'b1;
      end else begin
        delay_reg <= delay_reg + 1'b1;
      end
    end
  end

  // >= so a shrunk setting never strands the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outClk <= 1'b0;
      outRise <= 1'b0;
      phaseCnt_reg <= '0;
    end else begin
      outRise <= 1'b0;
      if (startNow) begin
        outClk <= 1'b1;
        outRise <= 1'b1;
        phaseCnt_reg <= (CW+1)'(1);
      end else if (tick && started_reg) begin
        if (outClk && phaseCnt_reg >= hiEff) begin
          outClk <= 1'b0;
          phaseCnt_reg <= (CW+1)'(1);
        end else if (!outClk && phaseCnt_reg >= loEff) begin
          outClk <= 1'b1;
          outRise <= 1'b1;
          phaseCnt_reg <= (CW+1)'(1);
        end else begin
          phaseCnt_reg <= phaseCnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

// [hw/ref_clock_sense.sv]
/*
  Loss sense for one reference input, measured against the other one.
  Assumes both edge inputs are one-cycle pulses in the system clock.
*/
`timescale 1ns/1ps
module ref_clock_sense (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // edges of the watched and the comparison input
  input wire logic ownRise,
  input wire logic otherRise,
  // loss flag
  output logic lost
);
  import pll_ctrl_pkg::*;

  logic [1:0] missCnt_reg;

  // frequency-independent: counts the other input's edges, not time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      missCnt_reg <= '0;
      lost <= 1'b0;
    end else if (ownRise) begin
      missCnt_reg <= '0;
      lost <= 1'b0;
    end else if (otherRise && !lost) begin
      missCnt_reg <= missCnt_reg + 1'b1;
      // first rise only opens the count: whole cycles are counted, so a
      // neighbour up to twice as fast never trips a running input
      if (missCnt_reg == 2'(LOSS_EDGES)) begin
        lost <= 1'b1;
      end
    end
  end
endmodule

// [pkg/pll_ctrl_pkg.sv]
/*
  Shared constants for the loop control block: register map, field
  positions, reset values, mode codes and switchover states.
  Assumes a 32-bit AXI4-Lite register port with 8 address bits.
*/
package pll_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_OUT = 7;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PHASE_OFS = 8'h08;
  localparam logic [7:0] CNT_BASE = 8'h10;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_OVERRIDE = 2'h2;
  localparam logic [1:0] MODE_RESET = MODE_AUTO;
  localparam int CNT_W = 8;
  localparam int INIT_W = 9;
  localparam int TAP_W = 3;
  localparam int NUM_TAPS = 8;
  localparam int HI_LSB = 0;
  localparam int LO_LSB = 8;
  localparam int INIT_LSB = 16;
  localparam int CASC_BIT = 31;
  localparam int ST_LOSS_P = 0;
  localparam int ST_LOSS_B = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_BUSY = 3;
  localparam int LOSS_EDGES = 2;
  localparam int REQ_HOLD_EDGES = 3;
  localparam logic [CNT_W-1:0] HI_RESET = 8'h01;
  localparam logic [CNT_W-1:0] LO_RESET = 8'h01;
  localparam logic [INIT_W-1:0] INIT_DEFAULT = 9'h001;
  localparam logic [TAP_W-1:0] TAP_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SW_IDLE, SW_GATE_OLD, SW_WAIT_NEW} sw_state_t;
endpackage

// [tb/pll_ctrl_sva.sv]
/*
  Port checks of the loop control block.
  Assumes one clock domain; attached by the bind at the foot.
*/
`timescale 1ns/1ps
module pll_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [pll_ctrl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // switchover
  input wire logic refClockPrimary,
  input wire logic refClockBackup,
  input wire logic refClockOut,
  input wire logic lossPrimary,
  input wire logic lossBackup,
  input wire logic activeSel
);
  import pll_ctrl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RESET_SEL: assert property ($rose(rstn) |-> (!activeSel) [*8])
    else $error("selection left primary just after reset");
  AST_WRITE_RESP: assert property (awvalid && awready && wvalid && wready |=> !awready && !bvalid ##1 bvalid)
    else $error("write response timing off");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not rearmed");
  AST_READ_RESP: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response timing off");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not rearmed");
  AST_SLVERR: assert property (arvalid && arready && araddr >= 8'h30 |=> rresp == RESP_SLVERR && rdata == '0)
    else $error("unmapped read not refused");
  AST_LOSS_P: assert property (lossPrimary && $rose(refClockPrimary) |-> ##[1:4] !lossPrimary)
    else $error("primary loss flag stuck while toggling");
  AST_LOSS_B: assert property (lossBackup && $rose(refClockBackup) |-> ##[1:4] !lossBackup)
    else $error("backup loss flag stuck while toggling");
  AST_FLIP_GATED: assert property ($changed(activeSel) |-> !refClockOut)
    else $error("selection changed while reference not gated");
endmodule
bind pll_ctrl pll_ctrl_sva portCheck (.clk, .rstn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .refClockPrimary,
  .refClockBackup, .refClockOut, .lossPrimary,
  .lossBackup, .activeSel);

// [tb/pll_ctrl_tb.sv]
/*
  Self-checking bench: registers, divider shape and phase, cascade,
  switchover in each mode. Assumes ref_sources as far side.
*/
`timescale 1ns/1ps
module pll_ctrl_tb;
  import pll_ctrl_pkg::*;
  localparam int LIM = 4000;
  localparam int LP = 0;
  localparam int LB = 1;
  localparam int SEL = 2;
  localparam int OUT = 3;
  // counter 3 starts one tick late
  localparam logic [71:0] INITS = {{4{9'h001}}, 9'h002, {3{9'h001}}};
  logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, vcoPhase;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic refClockPrimary, refClockBackup, switchReq, refClockOut, lossPrimary, lossBackup, activeSel;
  logic fbClkOut, runPrimary, runBackup, expSel;
  logic [NUM_OUT-1:0] clkOut;
  int badCount, totalChecks;
  ref_sources farSide (.clk, .rstn, .runPrimary, .runBackup, .refClockPrimary, .refClockBackup, .vcoPhase);
  pll_ctrl #(.CASCADE(8'h04), .INIT_VALUES(INITS)) DUT (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .refClockPrimary, .refClockBackup, .switchReq, .vcoPhase, .refClockOut,
    .lossPrimary, .lossBackup, .activeSel, .clkOut, .fbClkOut);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= LIM) begin
      check(32'(n), 32'(LIM - 1));
      conclude();
    end
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bound(n);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    bound(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic pick(input int k);
    logic [9:0] v;
    v = {clkOut, activeSel, lossBackup, lossPrimary};
    return v[k];
  endfunction
  // values read just after an edge are the ones that edge sampled
  task automatic waitFor(input int k, input logic v, output int n);
    for (n = 0; n < LIM; n++) begin
      if (pick(k) === v) break;
      @(posedge clk);
    end
    bound(n);
  endtask
  task automatic measure(input int i, output int hi, output int lo);
    int n;
    waitFor(OUT + i, 1'b0, n);
    waitFor(OUT + i, 1'b1, n);
    waitFor(OUT + i, 1'b0, hi);
    waitFor(OUT + i, 1'b1, lo);
  endtask
  task automatic testRegs();
    logic [31:0] d;
    logic [1:0] r;
    check({31'h0, activeSel}, 32'h0);
    axiRead(CTRL_OFS, d, r);
    check(d, 32'h0);
    axiRead(STATUS_OFS, d, r);
    check(d, 32'h0);
    axiRead(CNT_BASE, d, r);
    check(d, 32'h0001_0101);
    axiRead(CNT_BASE + 8'h0C, d, r);
    check(d, 32'h0002_0101);
    axiRead(8'h80, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    axiWrite(STATUS_OFS, 32'hFFFF_FFFF, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    $display("register test done");
  endtask
  task automatic testCounters();
    logic [31:0] d;
    logic [1:0] r;
    int hi, lo, a, b;
    axiWrite(CNT_BASE, 32'h0000_0302, r);
    measure(0, hi, lo);
    check(32'(hi), 32'd16);
    check(32'(hi + lo), 32'd40);
    axiWrite(PHASE_OFS, 32'h0000_0018, r);
    waitFor(OUT, 1'b0, a);
    waitFor(OUT, 1'b1, a);
    waitFor(OUT + 1, 1'b0, a);
    waitFor(OUT + 1, 1'b1, b);
    check(32'((a + b) % 8), 32'd3);
    measure(2, hi, lo);
    check(32'(hi + lo), 32'd32);
    axiWrite(CNT_BASE + 8'h08, 32'h0000_0101, r);
    axiRead(CNT_BASE + 8'h08, d, r);
    check(d, 32'h8001_0101);
    repeat (4) begin
      repeat (5) @(posedge clk);
      check({31'h0, clkOut[3]}, {31'h0, ~clkOut[4]});
    end
    $display("counter test done");
  endtask
  task automatic testManual();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    expSel = 1'b0;
    for (int k = 0; k < 4; k++) begin
      axiWrite(CTRL_OFS, (k < 2) ? 32'(MODE_MANUAL) : 32'(MODE_OVERRIDE), r);
      switchReq <= 1'b1;
      expSel = ~expSel;
      waitFor(SEL, expSel, n);
      axiRead(STATUS_OFS, d, r);
      check(d, {29'h0, expSel, 2'h0});
      switchReq <= 1'b0;
      repeat (40) @(posedge clk);
    end
    $display("manual test done");
  endtask
  task automatic testAuto();
    logic [1:0] r;
    int n;
    axiWrite(CTRL_OFS, 32'(MODE_AUTO), r);
    runPrimary <= 1'b0;
    waitFor(LP, 1'b1, n);
    check(32'(n >= 12 && n <= 40), 32'h1);
    check({31'h0, lossBackup}, 32'h0);
    waitFor(SEL, 1'b1, n);
    check({31'h0, lossPrimary}, 32'h1);
    runPrimary <= 1'b1;
    waitFor(LP, 1'b0, n);
    runBackup <= 1'b0;
    waitFor(SEL, 1'b0, n);
    check({31'h0, lossBackup}, 32'h1);
    runBackup <= 1'b1;
    waitFor(LB, 1'b0, n);
    $display("auto test done");
  endtask
  task automatic testBothLost();
    int n;
    runPrimary <= 1'b0;
    runBackup <= 1'b0;
    repeat (200) @(posedge clk);
    check({31'h0, activeSel}, 32'h0);
    runBackup <= 1'b1;
    waitFor(SEL, 1'b1, n);
    check({31'h0, lossPrimary}, 32'h1);
    runPrimary <= 1'b1;
    $display("both lost test done");
  endtask
  // loop reset after a switchover must bring back the primary input
  task automatic testReset();
    logic [31:0] d;
    logic [1:0] r;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, activeSel}, 32'h0);
    axiRead(STATUS_OFS, d, r);
    check(d, 32'h0);
    $display("reset test done");
  endtask
  initial begin
    badCount = 0;
    totalChecks = 0;
    rstn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, switchReq} <= '0;
    awaddr <= '0;
    araddr <= '0;
    wdata <= '0;
    wstrb <= 4'hF;
    runPrimary <= 1'b1;
    runBackup <= 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    testRegs();
    testCounters();
    testManual();
    testAuto();
    testBothLost();
    testReset();
    conclude();
  end
endmodule

// [tb/ref_sources.sv]
/*
  Far-side model: two stoppable reference sources and eight VCO taps.
  Assumes clk runs far faster than both references.
*/
`timescale 1ns/1ps
module ref_sources (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // run enables from the bench
  input wire logic runPrimary,
  input wire logic runBackup,
  // source outputs
  output logic refClockPrimary,
  output logic refClockBackup,
  output logic [pll_ctrl_pkg::NUM_TAPS-1:0] vcoPhase
);
  import pll_ctrl_pkg::*;
  logic [3:0] cntP;
  logic [3:0] cntB;
  logic [2:0] vco;
  // half periods 5 and 6 clk: within a factor two of each other
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cntP <= 4'h0;
      refClockPrimary <= 1'b0;
    end else if (runPrimary) begin
      cntP <= (cntP == 4'h4) ? 4'h0 : cntP + 4'h1;
      refClockPrimary <= refClockPrimary ^ (cntP == 4'h4);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cntB <= 4'h0;
      refClockBackup <= 1'b0;
    end else if (runBackup) begin
      cntB <= (cntB == 4'h5) ? 4'h0 : cntB + 4'h1;
      refClockBackup <= refClockBackup ^ (cntB == 4'h5);
    end
  end
  // tap i lags tap 0 by i clk, period eight clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vco <= 3'h0;
      vcoPhase <= '0;
    end else begin
      vco <= vco + 3'h1;
      for (int i = 0; i < NUM_TAPS; i++) begin
        vcoPhase[i] <= 3'(vco - 3'(i)) < 3'h4;
      end
    end
  end
endmodule
